// *** fru_eeprom_pkg.sv ***
// package for the identity eeprom: sizes, identity field map, states, pin carrier;
// also the pin synchroniser module that the eeprom top instantiates.
// assumes one clock i_clk and a synchronous active-high reset i_srst.
`timescale 1ns/1ps
`default_nettype none

package fru_eeprom_pkg;
  localparam int MEM_BYTES = 8192;
  localparam int ADDR_W = 13;
  localparam int BYTE_W = 8;
  localparam int ADDR_HI_W = ADDR_W - BYTE_W;
  localparam int PAGE_W = 5;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [PAGE_W-1:0] page_t;
  localparam page_t PAGE_LAST = 5'h1f;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // arbitrary neutral bus address
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
  localparam addr_t PROT_BASE = 13'h1800;
  localparam addr_t PRODUCT_ID_OFS = 13'h1800;
  localparam addr_t PRODUCT_ID_LEN = 13'h000c;
  localparam addr_t PART_NUM_OFS = 13'h180c;
  localparam addr_t PART_NUM_LEN = 13'h000a;
  localparam addr_t HW_REV_OFS = 13'h1816;
  localparam addr_t HW_REV_LEN = 13'h0006;
  localparam addr_t SERIAL_OFS = 13'h1822;
  localparam addr_t SERIAL_LEN = 13'h000e;
  localparam addr_t MFG_LOC_OFS = 13'h1830;
  localparam addr_t MFG_LOC_LEN = 13'h0028;
  localparam addr_t CUST_INFO_OFS = 13'h1862;
  localparam addr_t CUST_INFO_LEN = 13'h009e;
  localparam logic [1:0] IDX_HI = 2'h0;
  localparam logic [1:0] IDX_LO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [2:0] SYNC_RST = 3'h3;

  typedef enum logic [2:0] {
    FLD_SCRATCH = 3'h0,
    FLD_PRODUCT_ID = 3'h1,
    FLD_PART_NUM = 3'h2,
    FLD_HW_REV = 3'h3,
    FLD_SERIAL = 3'h4,
    FLD_MFG_LOC = 3'h5,
    FLD_CUST_INFO = 3'h6,
    FLD_FACTORY_OTHER = 3'h7
  } field_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_ev_s;

  function automatic logic in_field(input addr_t a, input addr_t ofs, input addr_t len);
    in_field = (a >= ofs) && (a < ofs + len);
  endfunction

  function automatic logic is_protected(input addr_t a);
    is_protected = (a >= PROT_BASE);
  endfunction

  function automatic field_e field_of(input addr_t a);
    if (!is_protected(a)) field_of = FLD_SCRATCH;
    else if (in_field(a, PRODUCT_ID_OFS, PRODUCT_ID_LEN)) field_of = FLD_PRODUCT_ID;
    else if (in_field(a, PART_NUM_OFS, PART_NUM_LEN)) field_of = FLD_PART_NUM;
    else if (in_field(a, HW_REV_OFS, HW_REV_LEN)) field_of = FLD_HW_REV;
    else if (in_field(a, SERIAL_OFS, SERIAL_LEN)) field_of = FLD_SERIAL;
    else if (in_field(a, MFG_LOC_OFS, MFG_LOC_LEN)) field_of = FLD_MFG_LOC;
    else if (in_field(a, CUST_INFO_OFS, CUST_INFO_LEN)) field_of = FLD_CUST_INFO;
    else field_of = FLD_FACTORY_OTHER;
  endfunction
endpackage

////////////////////////////////////////////////////////////////////////////////

module eeprom_pin_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  output fru_eeprom_pkg::bus_ev_s o_ev
);
  logic [2:0] raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  assign raw = {i_wp, i_sda, i_scl};

  // bit 0 scl, bit 1 sda, bit 2 write-protect pin
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        s1_q[g] <= fru_eeprom_pkg::SYNC_RST[g];
        s2_q[g] <= fru_eeprom_pkg::SYNC_RST[g];
        s3_q[g] <= fru_eeprom_pkg::SYNC_RST[g];
      end else begin
        s1_q[g] <= raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
      end
    end
  end

  always_comb begin
    o_ev.scl = s2_q[0];
    o_ev.sda = s2_q[1];
    o_ev.wp = s2_q[2];
    o_ev.scl_rise = s2_q[0] && !s3_q[0];
    o_ev.scl_fall = !s2_q[0] && s3_q[0];
    o_ev.start = s2_q[0] && s3_q[0] && s3_q[1] && !s2_q[1];
    o_ev.stop = s2_q[0] && s3_q[0] && !s3_q[1] && s2_q[1];
  end
endmodule

`default_nettype wire

// *** fru_identity_eeprom.sv ***
// two-wire serial identity and scratchpad eeprom, 8192 bytes, upper quarter lockable.
// assumes pins sampled through eeprom_pin_sync; sda open drain, oe high pulls low.
//
// Notes on behaviour
// RULE1 - 64 kbit serial memory on the two-wire bus for identity and scratchpad.
// RULE2 - upper quarter lockable, holds identity record; lower three quarters never locked.
// RULE3 - upper quarter unlocked by the pin level or by the software unlock input.
// RULE4 - pin pulled low by default, so the upper quarter stays locked.
// RULE5 - outside party drives unit-inserted pin high to unlock by hardware.
// RULE6 - host should prefer the software unlock over the pin method.
// RULE7 - writes organised in 32-byte pages.
// RULE8 - only start address needed; location advances after every data byte.
// RULE9 - beyond 32 bytes the location wraps to the first location given.
// RULE10 - host should keep each write within 32 bytes.
// RULE11 - upper quarter from location 6144 reserved for factory data.
// RULE12 - product id at 0x1800, part number 0x180c, hardware revision 0x1816.
// RULE13 - 14-byte serial number at 0x1822, 40-byte location field at 0x1830.
// RULE14 - 158-byte customer area from 0x1862 in the upper region.
// RULE15 - locked upper writes are dropped; lower writes always stored.
`timescale 1ns/1ps
`default_nettype none

module fru_identity_eeprom #(
  parameter logic [6:0] DEV_ADDR = fru_eeprom_pkg::DEV_ADDR_DEF
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_module_present,
  input wire logic i_sw_unlock,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_upper_unlocked,
  output fru_eeprom_pkg::field_e o_last_field
);
  fru_eeprom_pkg::bus_ev_s ev;
  fru_eeprom_pkg::state_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic unl_q, unl_d;
  logic [1:0] idx_q, idx_d;
  fru_eeprom_pkg::addr_t addr_q, addr_d;
  fru_eeprom_pkg::addr_t start_q, start_d;
  fru_eeprom_pkg::page_t wcnt_q, wcnt_d;
  fru_eeprom_pkg::field_e field_q, field_d;
  fru_eeprom_pkg::addr_t waddr;
  logic mem_we;
  logic ld;
  logic [7:0] rd_byte;
  logic [7:0] mem [0:fru_eeprom_pkg::MEM_BYTES-1];

  eeprom_pin_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_wp(i_module_present),
    .o_ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // nonvolatile array, never cleared by reset
  always_ff @(posedge i_clk) begin
    if (mem_we) begin // RULE1
      mem[waddr] <= sh_q;
    end
  end

  assign rd_byte = mem[addr_q];

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    oe_d = oe_q;
    rw_d = rw_q;
    nack_d = nack_q;
    idx_d = idx_q;
    addr_d = addr_q;
    start_d = start_q;
    wcnt_d = wcnt_q;
    field_d = field_q;
    mem_we = 1'h0;
    ld = 1'h0;
    unl_d = ev.wp || i_sw_unlock; // RULE3 RULE4
    waddr = start_q + fru_eeprom_pkg::addr_t'(wcnt_q); // RULE9
    if (ev.stop) begin
      st_d = fru_eeprom_pkg::ST_IDLE;
      oe_d = 1'h0;
    end else if (ev.start) begin
      st_d = fru_eeprom_pkg::ST_DEV;
      bit_d = 4'h0;
      oe_d = 1'h0;
    end else begin
      unique case (st_q)
        fru_eeprom_pkg::ST_IDLE: begin
        end
        fru_eeprom_pkg::ST_DEV, fru_eeprom_pkg::ST_RX: begin
          if (ev.scl_rise) begin
            sh_d = {sh_q[fru_eeprom_pkg::BYTE_W-2:0], ev.sda};
            bit_d = bit_q + 4'h1;
          end else if (ev.scl_fall && bit_q == fru_eeprom_pkg::BIT_LAST) begin
            bit_d = 4'h0;
            if (st_q == fru_eeprom_pkg::ST_DEV) begin
              if (sh_q[fru_eeprom_pkg::BYTE_W-1:1] == DEV_ADDR) begin
                oe_d = 1'h1;
                rw_d = sh_q[0];
                idx_d = fru_eeprom_pkg::IDX_HI;
                st_d = fru_eeprom_pkg::ST_ACK;
              end else begin
                st_d = fru_eeprom_pkg::ST_IDLE;
              end
            end else begin
              oe_d = 1'h1;
              st_d = fru_eeprom_pkg::ST_ACK;
              if (idx_q == fru_eeprom_pkg::IDX_HI) begin
                addr_d = {sh_q[fru_eeprom_pkg::ADDR_HI_W-1:0],
                          addr_q[fru_eeprom_pkg::BYTE_W-1:0]};
                idx_d = fru_eeprom_pkg::IDX_LO;
              end else if (idx_q == fru_eeprom_pkg::IDX_LO) begin
                addr_d = {addr_q[fru_eeprom_pkg::ADDR_W-1:fru_eeprom_pkg::BYTE_W], sh_q};
                start_d = addr_d; // RULE8
                wcnt_d = '0;
                idx_d = fru_eeprom_pkg::IDX_DATA;
              end else begin
                mem_we = !fru_eeprom_pkg::is_protected(waddr) || unl_q; // RULE2 RULE11 RULE15
                wcnt_d = wcnt_q + fru_eeprom_pkg::page_t'(1); // RULE7 RULE9
                addr_d = waddr + fru_eeprom_pkg::addr_t'(1); // RULE8
                field_d = fru_eeprom_pkg::field_of(waddr); // RULE12 RULE13 RULE14
              end
            end
          end
        end
        fru_eeprom_pkg::ST_ACK: begin
          if (ev.scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              ld = 1'h1;
            end else begin
              oe_d = 1'h0;
              st_d = fru_eeprom_pkg::ST_RX;
            end
          end
        end
        fru_eeprom_pkg::ST_TX: begin
          if (ev.scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (ev.scl_fall) begin
            if (bit_q == fru_eeprom_pkg::BIT_LAST) begin
              oe_d = 1'h0;
              bit_d = 4'h0;
              st_d = fru_eeprom_pkg::ST_MACK;
            end else begin
              sh_d = {sh_q[fru_eeprom_pkg::BYTE_W-2:0], 1'h0};
              oe_d = !sh_q[fru_eeprom_pkg::BYTE_W-2];
            end
          end
        end
        fru_eeprom_pkg::ST_MACK: begin
          if (ev.scl_rise) begin
            nack_d = ev.sda;
          end else if (ev.scl_fall) begin
            if (nack_q) begin
              st_d = fru_eeprom_pkg::ST_IDLE;
            end else begin
              ld = 1'h1;
            end
          end
        end
        default: begin
          st_d = fru_eeprom_pkg::ST_IDLE;
          oe_d = 1'h0;
        end
      endcase
    end
    // read byte load: first bit driven at once, pointer moves on
    if (ld) begin
      sh_d = rd_byte;
      oe_d = !rd_byte[fru_eeprom_pkg::BYTE_W-1];
      addr_d = addr_q + fru_eeprom_pkg::addr_t'(1);
      field_d = fru_eeprom_pkg::field_of(addr_q);
      st_d = fru_eeprom_pkg::ST_TX;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= fru_eeprom_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      oe_q <= 1'h0;
      rw_q <= 1'h0;
      nack_q <= 1'h0;
      unl_q <= 1'h0;
      idx_q <= fru_eeprom_pkg::IDX_HI;
      addr_q <= '0;
      start_q <= '0;
      wcnt_q <= '0;
      field_q <= fru_eeprom_pkg::FLD_SCRATCH;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      unl_q <= unl_d;
      idx_q <= idx_d;
      addr_q <= addr_d;
      start_q <= start_d;
      wcnt_q <= wcnt_d;
      field_q <= field_d;
    end
  end

  // sda data flop is always low; only the enable moves
  always_ff @(posedge i_clk) begin
    o_sda_o <= 1'h0;
  end

  assign o_sda_oe = oe_q;
  assign o_upper_unlocked = unl_q;
  assign o_last_field = field_q;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_addr_ack_drive: assert property ( // RULE1
    (st_q == fru_eeprom_pkg::ST_DEV && ev.scl_fall && !ev.start && !ev.stop &&
     bit_q == fru_eeprom_pkg::BIT_LAST && sh_q[fru_eeprom_pkg::BYTE_W-1:1] == DEV_ADDR)
    |=> o_sda_oe && st_q == fru_eeprom_pkg::ST_ACK)
    else $error("address match not acknowledged");

  a_lock_blocks_write: assert property ( // RULE15
    mem_we |-> (!fru_eeprom_pkg::is_protected(waddr) || o_upper_unlocked))
    else $error("write into locked upper quarter");

  a_locked_kept: assert property ( // RULE15
    (st_q == fru_eeprom_pkg::ST_RX && ev.scl_fall && !ev.start && !ev.stop &&
     bit_q == fru_eeprom_pkg::BIT_LAST && idx_q == fru_eeprom_pkg::IDX_DATA &&
     fru_eeprom_pkg::is_protected(waddr) && !o_upper_unlocked)
    |=> mem[$past(waddr)] == $past(mem[waddr]))
    else $error("locked upper byte changed");

  a_lower_write_taken: assert property ( // RULE2
    (st_q == fru_eeprom_pkg::ST_RX && ev.scl_fall && !ev.start && !ev.stop &&
     bit_q == fru_eeprom_pkg::BIT_LAST && idx_q == fru_eeprom_pkg::IDX_DATA &&
     waddr < fru_eeprom_pkg::PROT_BASE) |-> mem_we)
    else $error("lower quarter write dropped");

  a_page_wrap: assert property ( // RULE9
    (mem_we && wcnt_q == fru_eeprom_pkg::PAGE_LAST) |=> wcnt_q == '0 && waddr == start_q)
    else $error("page count did not wrap to first location");

  a_addr_advance: assert property ( // RULE8
    mem_we |=> addr_q == fru_eeprom_pkg::addr_t'($past(waddr) + 1'h1))
    else $error("location did not advance after data byte");

  a_stop_release: assert property (
    ev.stop |=> st_q == fru_eeprom_pkg::ST_IDLE ##1 !o_sda_oe)
    else $error("stop did not release the bus");

  a_unlock_follow: assert property ( // RULE3
    ##1 o_upper_unlocked == $past(ev.wp || i_sw_unlock))
    else $error("unlock does not follow pin or software input");

  a_ack_release: assert property (
    (st_q == fru_eeprom_pkg::ST_ACK && ev.scl_fall && !rw_q && !ev.start && !ev.stop)
    |=> !o_sda_oe [*2])
    else $error("sda held after write acknowledge");

  c_protected_write: cover property (
    mem_we && fru_eeprom_pkg::is_protected(waddr));
  c_page_wrap: cover property (
    mem_we && wcnt_q == fru_eeprom_pkg::PAGE_LAST);
  c_read_byte: cover property (
    st_q == fru_eeprom_pkg::ST_TX ##[1:400] st_q == fru_eeprom_pkg::ST_MACK);
endmodule

`default_nettype wire

// *** bus_host_model.sv ***
// two-wire bus host model: start, repeated start, stop, byte out, byte in.
// assumes one system clock; scl driven directly, sda open drain, pulled up in the bench.
`timescale 1ns/1ps
`default_nettype none

module bus_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask

  // data set in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    tk(6);
    o_scl = 1'b1;
    tk(3);
    r = i_sda;
    tk(3);
    o_scl = 1'b0;
    tk(6);
  endtask

  // also serves as repeated start
  task automatic start();
    o_sda_low = 1'b0;
    tk(6);
    o_scl = 1'b1;
    tk(6);
    o_sda_low = 1'b1;
    tk(6);
    o_scl = 1'b0;
    tk(6);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    tk(6);
    o_scl = 1'b1;
    tk(6);
    o_sda_low = 1'b0;
    tk(6);
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
// bench for the identity eeprom: lower writes, page wrap, lock, field map, address miss.
// assumes bus_host_model on the far side; sda wire pulled up, low if either side pulls.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk;
  logic srst;
  logic present;
  logic unlock;
  logic scl;
  logic host_low;
  logic sda_o;
  logic sda_oe;
  logic unlocked;
  fru_eeprom_pkg::field_e last_field;
  wire sda_w = !(sda_oe || host_low);
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] rbuf [0:39];

  fru_identity_eeprom u_fru_identity_eeprom (.i_clk(clk), .i_srst(srst), .i_scl(scl),
    .i_sda(sda_w), .i_module_present(present), .i_sw_unlock(unlock), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .o_upper_unlocked(unlocked), .o_last_field(last_field));
  bus_host_model u_bus_host_model (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_low(host_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tx(input logic [7:0] d, input logic e);
    logic ack;
    u_bus_host_model.byte_tx(d, ack);
    chk("ack", {15'h0, e}, {15'h0, ack});
  endtask

  task automatic addr(input fru_eeprom_pkg::addr_t a);
    u_bus_host_model.start();
    tx({fru_eeprom_pkg::DEV_ADDR_DEF, 1'b0}, 1'b0);
    tx({3'h0, a[12:8]}, 1'b0);
    tx(a[7:0], 1'b0);
  endtask

  // byte i carries d + i
  task automatic wr(input fru_eeprom_pkg::addr_t a, input logic [7:0] d, input int n);
    addr(a);
    for (int i = 0; i < n; i++) begin
      tx(d + 8'(i), 1'b0);
    end
    u_bus_host_model.stop();
  endtask

  task automatic rd(input fru_eeprom_pkg::addr_t a, input int n);
    addr(a);
    u_bus_host_model.start();
    tx({fru_eeprom_pkg::DEV_ADDR_DEF, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_bus_host_model.byte_rx(i == n - 1, rbuf[i]);
    end
    u_bus_host_model.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  task automatic t_reset();
    chk("oe", 16'h0, {15'h0, sda_oe});
    chk("sda_o", 16'h0, {15'h0, sda_o});
    chk("unlocked", 16'h0, {15'h0, unlocked});
    chk("field", 16'h0, {13'h0, last_field});
  endtask

  task automatic t_lower();
    wr(13'h0010, 8'h5a, 3);
    rd(13'h0010, 3);
    for (int i = 0; i < 3; i++) begin
      chk("lower", {8'h0, 8'h5a + 8'(i)}, {8'h0, rbuf[i]});
    end
  endtask

  // 34 bytes: last two land on the first two
  task automatic t_wrap();
    wr(13'h0100, 8'h00, 34);
    // current-address read: pointer sits one past the last byte written
    u_bus_host_model.start();
    tx({fru_eeprom_pkg::DEV_ADDR_DEF, 1'b1}, 1'b0);
    u_bus_host_model.byte_rx(1'b1, rbuf[0]);
    u_bus_host_model.stop();
    chk("cur read", 16'h0002, {8'h0, rbuf[0]});
    rd(13'h0100, 32);
    for (int i = 0; i < 32; i++) begin
      chk("page", (i < 2) ? 16'(i + 32) : 16'(i), {8'h0, rbuf[i]});
    end
  endtask

  task automatic t_lock();
    unlock = 1'b1;
    tk(2);
    chk("sw unlock", 16'h1, {15'h0, unlocked});
    wr(13'h1800, 8'h11, 1);
    unlock = 1'b0;
    tk(2);
    chk("relock", 16'h0, {15'h0, unlocked});
    wr(13'h17ff, 8'h77, 2);
    rd(13'h17ff, 2);
    chk("below lock", 16'h77, {8'h0, rbuf[0]});
    chk("locked", 16'h11, {8'h0, rbuf[1]});
    present = 1'b1;
    tk(4);
    chk("pin unlock", 16'h1, {15'h0, unlocked});
    wr(13'h1800, 8'h33, 1);
    rd(13'h1800, 1);
    chk("pin write", 16'h33, {8'h0, rbuf[0]});
    present = 1'b0;
    tk(4);
  endtask

  task automatic t_fields();
    logic [12:0] ofs [8] = '{13'h0000, 13'h1800, 13'h180c, 13'h1816, 13'h1822, 13'h1830,
      13'h1862, 13'h181c};
    logic [12:0] len [8] = '{13'h1800, 13'h000c, 13'h000a, 13'h0006, 13'h000e, 13'h0028,
      13'h009e, 13'h0006};
    logic [2:0] fc [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    unlock = 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(ofs[k], 8'h20, 1);
      chk("field start", {13'h0, fc[k]}, {13'h0, last_field});
      wr(ofs[k] + len[k] - 13'h1, 8'h20, 1);
      chk("field end", {13'h0, fc[k]}, {13'h0, last_field});
    end
    unlock = 1'b0;
  endtask

  task automatic t_noack();
    u_bus_host_model.start();
    tx({fru_eeprom_pkg::DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1);
    u_bus_host_model.stop();
    chk("oe idle", 16'h0, {15'h0, sda_oe});
  endtask

  initial begin
    srst = 1'b1;
    present = 1'b0;
    unlock = 1'b0;
    tk(5);
    srst = 1'b0;
    tk(3);
    t_reset();
    t_lower();
    t_wrap();
    t_lock();
    t_fields();
    t_noack();
    tally_and_finish();
  end
endmodule

`default_nettype wire
